// ===== logic/classify_params.svh
// constants of the per-port received-frame classifier
`ifndef CLASSIFY_PARAMS_SVH
`define CLASSIFY_PARAMS_SVH
// =============================================
// sizes
`define NFILT      8
`define NBRANCH    9
`define DEF_BRANCH 4'h8
`define CFGW       64
`define BUFB       96
// =============================================
// per-filter word index, register address = {1'b0, filter[2:0], word[5:0]}
`define W_CTRL 0
`define W_DMAC 1
`define W_DMSK 3
`define W_SMAC 5
`define W_SMSK 7
`define W_TYPE 9
`define W_CVID 10
`define W_SVID 11
`define W_PCP  12
`define W_MTL  13
`define W_MBL  15
`define W_MEXP 17
`define W_V4S  18
`define W_V4D  20
`define W_V4X  22
`define W_V6S  23
`define W_V6D  31
`define W_V6F  39
`define W_V6X  41
`define W_UDP  42
`define W_GEN  43
// =============================================
// control word bits
`define C_EN     0
`define C_LAST   22
`define C_UDPSRC 31
// =============================================
// status addresses
`define S_TOTAL 10'h200
`define S_LAST  10'h201
`define S_BR0   10'h210
`define S_BREND 10'h219
// =============================================
// protocol codes
`define ET_CTAG 16'h8100
`define ET_STAG 16'h88a8
`define ET_QQ1  16'h9100
`define ET_QQ2  16'h9200
`define ET_QQ3  16'h9300
`define ET_MPU  16'h8847
`define ET_MPM  16'h8848
`define ET_IP4  16'h0800
`define ET_IP6  16'h86dd
`define PR_UDP  8'h11
`endif

// ===== logic/classify_pkg.sv
// types shared by the per-port received-frame classifier
`include "classify_params.svh"
package classify_pkg;
	typedef struct packed {
		logic       valid;
		logic       sof;
		logic       eof;
		logic [7:0] data;
	} rx_t;
	typedef logic [`BUFB-1:0][7:0]  fbuf_t;
	typedef logic [`CFGW-1:0][31:0] fcfg_t;
	typedef struct packed {
		logic         has_type;
		logic [15:0]  etype;
		logic [47:0]  dmac;
		logic [47:0]  smac;
		logic         has_s;
		logic [11:0]  svid;
		logic [2:0]   spcp;
		logic         has_c;
		logic [11:0]  cvid;
		logic [2:0]   cpcp;
		logic         has_mt;
		logic [19:0]  mt_lbl;
		logic [2:0]   mt_exp;
		logic         has_mb;
		logic [19:0]  mb_lbl;
		logic [2:0]   mb_exp;
		logic         is4;
		logic [31:0]  v4s;
		logic [31:0]  v4d;
		logic [7:0]   v4p;
		logic         is6;
		logic [127:0] v6s;
		logic [127:0] v6d;
		logic [19:0]  flow;
		logic [7:0]   nh;
		logic [5:0]   dscp;
		logic         is_udp;
		logic [15:0]  sport;
		logic [15:0]  dport;
	} hdr_t;
	typedef struct packed {
		logic                  valid;
		logic [3:0]            branch;
		logic [`NBRANCH-1:0]   onehot;
		logic [`NFILT-1:0]     hits;
	} cls_t;
endpackage

// ===== logic/filter_match.sv
// one filter: all enabled criteria must hold
`timescale 1ns/1ps
`include "classify_params.svh"
module filter_match (
	input  wire classify_pkg::fcfg_t cfg,
	input  wire classify_pkg::hdr_t  hdr,
	input  wire classify_pkg::fbuf_t frame,
	input  wire logic [6:0]          len,
	output logic                     match
);
	import classify_pkg::*;
	logic [`C_LAST:1] res;
	logic [7:0]       go;
	logic [15:0]      gw;
	logic [15:0]      pt;
	function automatic logic mm(input logic [127:0] a, input logic [127:0] r, input logic [127:0] m);
		return (a & m) == (r & m);
	endfunction
	function automatic logic rng(input logic [19:0] v, input logic [19:0] lo, input logic [19:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction
	// =============================================
	// criteria; a missing header fails its criterion
	always_comb begin
		go = {1'b0, cfg[`W_GEN][6:0]};
		gw = (go < 8'(`BUFB - 1)) ? {frame[go[6:0]], frame[go[6:0] + 7'h1]} : 16'h0;
		pt = cfg[`W_CTRL][`C_UDPSRC] ? hdr.sport : hdr.dport;
		res[1]  = hdr.has_type && mm(128'(hdr.dmac), 128'({cfg[`W_DMAC+1][15:0], cfg[`W_DMAC]}),
			128'({cfg[`W_DMSK+1][15:0], cfg[`W_DMSK]}));
		res[2]  = hdr.has_type && mm(128'(hdr.smac), 128'({cfg[`W_SMAC+1][15:0], cfg[`W_SMAC]}),
			128'({cfg[`W_SMSK+1][15:0], cfg[`W_SMSK]}));
		res[3]  = hdr.has_type && mm(128'(hdr.etype), 128'(cfg[`W_TYPE][15:0]), 128'(cfg[`W_TYPE][31:16]));
		res[4]  = hdr.has_c && mm(128'(hdr.cvid), 128'(cfg[`W_CVID][11:0]), 128'(cfg[`W_CVID][27:16]));
		res[5]  = hdr.has_s && mm(128'(hdr.svid), 128'(cfg[`W_SVID][11:0]), 128'(cfg[`W_SVID][27:16]));
		res[6]  = hdr.has_c && mm(128'(hdr.cpcp), 128'(cfg[`W_PCP][2:0]), 128'(cfg[`W_PCP][6:4]));
		res[7]  = hdr.has_s && mm(128'(hdr.spcp), 128'(cfg[`W_PCP][10:8]), 128'(cfg[`W_PCP][14:12]));
		// single value is a range with equal bounds, both inclusive
		res[8]  = hdr.has_mt && rng(hdr.mt_lbl, cfg[`W_MTL][19:0], cfg[`W_MTL+1][19:0]);
		res[9]  = hdr.has_mt && rng(20'(hdr.mt_exp), 20'(cfg[`W_MEXP][2:0]), 20'(cfg[`W_MEXP][6:4]));
		res[10] = hdr.has_mb && rng(hdr.mb_lbl, cfg[`W_MBL][19:0], cfg[`W_MBL+1][19:0]);
		res[11] = hdr.has_mb && rng(20'(hdr.mb_exp), 20'(cfg[`W_MEXP][10:8]), 20'(cfg[`W_MEXP][14:12]));
		res[12] = hdr.is4 && mm(128'(hdr.v4s), 128'(cfg[`W_V4S]), 128'(cfg[`W_V4S+1]));
		res[13] = hdr.is4 && mm(128'(hdr.v4d), 128'(cfg[`W_V4D]), 128'(cfg[`W_V4D+1]));
		res[14] = hdr.is4 && (hdr.v4p == cfg[`W_V4X][7:0]);
		res[15] = hdr.is4 && rng(20'(hdr.dscp), 20'(cfg[`W_V4X][13:8]), 20'(cfg[`W_V4X][21:16]));
		res[16] = hdr.is6 && mm(hdr.v6s, {cfg[`W_V6S+3], cfg[`W_V6S+2], cfg[`W_V6S+1], cfg[`W_V6S]},
			{cfg[`W_V6S+7], cfg[`W_V6S+6], cfg[`W_V6S+5], cfg[`W_V6S+4]});
		res[17] = hdr.is6 && mm(hdr.v6d, {cfg[`W_V6D+3], cfg[`W_V6D+2], cfg[`W_V6D+1], cfg[`W_V6D]},
			{cfg[`W_V6D+7], cfg[`W_V6D+6], cfg[`W_V6D+5], cfg[`W_V6D+4]});
		res[18] = hdr.is6 && mm(128'(hdr.flow), 128'(cfg[`W_V6F][19:0]), 128'(cfg[`W_V6F+1][19:0]));
		res[19] = hdr.is6 && (hdr.nh == cfg[`W_V6X][7:0]);
		res[20] = hdr.is6 && rng(20'(hdr.dscp), 20'(cfg[`W_V6X][13:8]), 20'(cfg[`W_V6X][21:16]));
		res[21] = hdr.is_udp && rng(20'(pt), 20'(cfg[`W_UDP][15:0]), 20'(cfg[`W_UDP][31:16]));
		res[22] = (go + 8'h2 <= {1'b0, len}) &&
			mm(128'(gw), 128'(cfg[`W_GEN+1][15:0]), 128'(cfg[`W_GEN+1][31:16]));
		match = cfg[`W_CTRL][`C_EN] && (&(~cfg[`W_CTRL][`C_LAST:1] | res));
	end
endmodule

// ===== logic/frame_capture.sv
// captures the leading bytes of each received frame
`timescale 1ns/1ps
`include "classify_params.svh"
module frame_capture (
	input  wire logic                clock,
	input  wire logic                resetn,
	input  wire classify_pkg::rx_t   rx,
	output classify_pkg::fbuf_t      frame,
	output logic [6:0]               len,
	output logic                     done
);
	import classify_pkg::*;
	typedef struct packed {
		fbuf_t      bytes;
		logic [6:0] cnt;
		logic       done;
	} cap_t;
	cap_t st_ff;
	cap_t nxt_st;
	// =============================================
	// byte store; bytes past the window are counted out, fields there are never needed
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		if (rx.valid) begin
			if (rx.sof) begin
				nxt_st.bytes[0] = rx.data;
				nxt_st.cnt = 7'h1;
			end else if (st_ff.cnt < 7'(`BUFB)) begin
				nxt_st.bytes[st_ff.cnt] = rx.data;
				nxt_st.cnt = st_ff.cnt + 7'h1;
			end
			nxt_st.done = rx.eof;
		end
	end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign frame = st_ff.bytes;
	assign len   = st_ff.cnt;
	assign done  = st_ff.done;
endmodule

// ===== logic/frame_classifier.sv
// top of the per-port received-frame classifier: header parse, filters, branch choice, registers
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "classify_params.svh"
// =============================================
module frame_classifier (
	input  wire logic                CLOCK,
	input  wire logic                RESETN,
	input  wire logic [9:0]          REG_ADDR,
	input  wire logic [31:0]         REG_WDATA,
	input  wire logic                REG_WR,
	input  wire logic                REG_RD,
	output logic [31:0]              REG_RDATA,
	input  wire classify_pkg::rx_t   RX,
	output classify_pkg::cls_t       CLS
);
	import classify_pkg::*;
	typedef struct packed {
		logic [31:0]                 rdata;
		cls_t                        cls;
		logic [3:0]                  last;
		logic [31:0]                 total;
		logic [`NBRANCH-1:0][15:0]   brcnt;
	} st_t;
	st_t             st_ff;
	st_t             nxt_st;
	fcfg_t           cfg_mem [`NFILT];
	fbuf_t           frame;
	logic [6:0]      len;
	logic            done;
	hdr_t            hdr;
	logic [`NFILT-1:0] hits;
	logic [7:0]      e;
	logic [7:0]      p;
	logic [7:0]      l4;
	logic [15:0]     t;
	logic [15:0]     x;
	logic [31:0]     m;
	logic [3:0]      ver;
	logic [3:0]      br;
	logic [3:0]      bidx;
	logic            clr;

	// =============================================
	// byte window access; bytes outside the window read as zero
	function automatic logic [7:0] bt(input fbuf_t f, input logic [7:0] i);
		return (i < 8'(`BUFB)) ? f[i[6:0]] : 8'h0;
	endfunction
	function automatic logic [15:0] w16(input fbuf_t f, input logic [7:0] i);
		return {bt(f, i), bt(f, i + 8'h1)};
	endfunction
	function automatic logic [31:0] w32(input fbuf_t f, input logic [7:0] i);
		return {w16(f, i), w16(f, i + 8'h2)};
	endfunction
	function automatic logic fits(input logic [6:0] n, input logic [7:0] need);
		return {1'b0, n} >= need;
	endfunction
	function automatic logic is_stag(input logic [15:0] v);
		return (v == `ET_STAG) || (v == `ET_QQ1) || (v == `ET_QQ2) || (v == `ET_QQ3);
	endfunction
	// lowest set index wins; no hit gives the default branch
	function automatic logic [3:0] pick(input logic [`NFILT-1:0] h);
		logic [3:0] r;
		r = `DEF_BRANCH;
		for (int i = `NFILT - 1; i >= 0; i--) begin
			if (h[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	// =============================================
	// capture of the leading bytes
	frame_capture u_cap (
		.clock  (CLOCK),
		.resetn (RESETN),
		.rx     (RX),
		.frame  (frame),
		.len    (len),
		.done   (done)
	);

	// =============================================
	// header parse from the captured window, valid in the cycle done is high
	always_comb begin
		hdr = '0;
		e   = 8'd12;
		t   = w16(frame, 8'd12);
		x   = 16'h0;
		m   = 32'h0;
		ver = 4'h0;
		l4  = 8'h0;
		for (int k = 0; k < 6; k++) begin
			hdr.dmac = {hdr.dmac[39:0], bt(frame, 8'(k))};
			hdr.smac = {hdr.smac[39:0], bt(frame, 8'(k + 6))};
		end
		// outer service tag, then customer tag
		if (is_stag(t) && fits(len, 8'd18)) begin
			x = w16(frame, 8'd14);
			hdr.has_s = 1'b1;
			hdr.spcp = x[15:13];
			hdr.svid = x[11:0];
			e = 8'd16;
			t = w16(frame, 8'd16);
		end
		if ((t == `ET_CTAG) && fits(len, e + 8'd6)) begin
			x = w16(frame, e + 8'd2);
			hdr.has_c = 1'b1;
			hdr.cpcp = x[15:13];
			hdr.cvid = x[11:0];
			e = e + 8'd4;
			t = w16(frame, e);
		end
		hdr.has_type = fits(len, e + 8'd2);
		hdr.etype = t;
		p = e + 8'd2;
		if (t == `ET_IP4) begin
			ver = 4'h4;
		end else if (t == `ET_IP6) begin
			ver = 4'h6;
		end
		// label stack: first entry is top, second (when present) is bottom
		if (((t == `ET_MPU) || (t == `ET_MPM)) && fits(len, p + 8'd4)) begin
			m = w32(frame, p);
			hdr.has_mt = 1'b1;
			hdr.mt_lbl = m[31:12];
			hdr.mt_exp = m[11:9];
			p = p + 8'd4;
			if (!m[8] && fits(len, p + 8'd4)) begin
				m = w32(frame, p);
				hdr.has_mb = 1'b1;
				hdr.mb_lbl = m[31:12];
				hdr.mb_exp = m[11:9];
				p = p + 8'd4;
			end
			// payload after the stack is guessed from its version nibble
			x = w16(frame, p);
			ver = x[15:12];
		end
		// network layer only when the frame really carries it
		if ((ver == 4'h4) && fits(len, p + 8'd20)) begin
			x = w16(frame, p);
			hdr.is4 = 1'b1;
			hdr.dscp = x[7:2];
			hdr.v4p = bt(frame, p + 8'd9);
			hdr.v4s = w32(frame, p + 8'd12);
			hdr.v4d = w32(frame, p + 8'd16);
			l4 = p + {2'b00, x[11:8], 2'b00};
			hdr.is_udp = (hdr.v4p == `PR_UDP);
		end else if ((ver == 4'h6) && fits(len, p + 8'd40)) begin
			x = w16(frame, p);
			hdr.is6 = 1'b1;
			hdr.dscp = x[11:6];
			hdr.flow = {x[3:0], w16(frame, p + 8'd2)};
			hdr.nh = bt(frame, p + 8'd6);
			for (int k = 0; k < 4; k++) begin
				hdr.v6s = {hdr.v6s[95:0], w32(frame, p + 8'(8 + 4 * k))};
				hdr.v6d = {hdr.v6d[95:0], w32(frame, p + 8'(24 + 4 * k))};
			end
			l4 = p + 8'd40;
			hdr.is_udp = (hdr.nh == `PR_UDP);
		end
		// transport ports only for UDP payload that fits in the window
		if (hdr.is_udp && fits(len, l4 + 8'd4)) begin
			hdr.sport = w16(frame, l4);
			hdr.dport = w16(frame, l4 + 8'd2);
		end else begin
			hdr.is_udp = 1'b0;
		end
	end

	// =============================================
	// filter bank, every filter sees the same header at once
	generate
		for (genvar g = 0; g < `NFILT; g++) begin : g_filt
			filter_match u_match (
				.cfg   (cfg_mem[g]),
				.hdr   (hdr),
				.frame (frame),
				.len   (len),
				.match (hits[g])
			);
		end
	endgenerate

	// =============================================
	// filter settings; a change takes effect from the next frame decision
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			for (int f = 0; f < `NFILT; f++) begin
				cfg_mem[f] <= '0;
			end
		end else if (REG_WR && !REG_ADDR[9]) begin
			cfg_mem[REG_ADDR[8:6]][REG_ADDR[5:0]] <= REG_WDATA;
		end
	end

	// =============================================
	// decision, counters and read port
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rdata = 32'h0;
		nxt_st.cls.valid = 1'b0;
		br = pick(hits);
		bidx = 4'(REG_ADDR - `S_BR0);
		clr = REG_WR && (REG_ADDR == `S_TOTAL);
		// clearing first, so a decision in the same cycle is still counted
		if (clr) begin
			nxt_st.total = 32'h0;
			nxt_st.brcnt = '0;
		end
		if (done) begin
			nxt_st.cls.valid = 1'b1;
			nxt_st.cls.branch = br;
			nxt_st.cls.onehot = `NBRANCH'(1) << br;
			nxt_st.cls.hits = hits;
			nxt_st.last = br;
			nxt_st.total = nxt_st.total + 32'h1;
			nxt_st.brcnt[br] = nxt_st.brcnt[br] + 16'h1;
		end
		if (REG_RD) begin
			if (!REG_ADDR[9]) begin
				nxt_st.rdata = cfg_mem[REG_ADDR[8:6]][REG_ADDR[5:0]];
			end else if (REG_ADDR == `S_TOTAL) begin
				nxt_st.rdata = st_ff.total;
			end else if (REG_ADDR == `S_LAST) begin
				nxt_st.rdata = {28'h0, st_ff.last};
			end else if ((REG_ADDR >= `S_BR0) && (REG_ADDR < `S_BREND)) begin
				nxt_st.rdata = {16'h0, st_ff.brcnt[bidx]};
			end
		end
	end
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign REG_RDATA = st_ff.rdata;
	assign CLS       = st_ff.cls;
endmodule

// ===== testbench/frame_classifier_assertions.sv
// port-level assertion checker for the received-frame classifier
`timescale 1ns/1ps
module frame_classifier_assertions (
	input wire logic               CLOCK,
	input wire logic               RESETN,
	input wire logic [9:0]         REG_ADDR,
	input wire logic [31:0]        REG_WDATA,
	input wire logic               REG_WR,
	input wire logic               REG_RD,
	input wire logic [31:0]        REG_RDATA,
	input wire classify_pkg::rx_t  RX,
	input wire classify_pkg::cls_t CLS
);
	import classify_pkg::*;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESETN);
	// =============================================
	// register port and decision output
	rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("read data seen outside the answer cycle");
	onehot_branch_a: assert property (CLS.valid |-> CLS.onehot == (9'h1 << CLS.branch))
		else $error("onehot does not match branch");
	branch_range_a: assert property (CLS.valid |-> CLS.branch <= 4'h8)
		else $error("branch index out of range");
	// a set bit below the chosen filter means a higher index stole the frame
	lowest_wins_a: assert property (CLS.valid && CLS.hits != 8'h0 |->
		CLS.hits[CLS.branch[2:0]] && CLS.branch < 4'h8 && (CLS.hits & ((8'h1 << CLS.branch) - 8'h1)) == 8'h0)
		else $error("matching filter with lower index was skipped");
	default_branch_a: assert property (CLS.valid && CLS.hits == 8'h0 |-> CLS.branch == 4'h8)
		else $error("unmatched frame not sent to default branch");
	answer_delay_a: assert property (RX.valid && RX.eof |-> ##2 CLS.valid)
		else $error("no decision two cycles after end of frame");
	no_duplicate_a: assert property (CLS.valid |-> $past(RX.valid && RX.eof, 2))
		else $error("decision without a frame end");
	result_held_a: assert property (!CLS.valid |-> $stable(CLS.branch) && $stable(CLS.hits))
		else $error("decision changed between frames");
	// =============================================
	// main scenarios reached
	default_seen_c: cover property (CLS.valid && CLS.branch == 4'h8);
	conflict_seen_c: cover property (CLS.valid && $countones(CLS.hits) > 1);
	read_seen_c: cover property (REG_RD ##1 REG_RDATA != 32'h0);
endmodule
bind frame_classifier frame_classifier_assertions chk_inst (
	.CLOCK     (CLOCK),
	.RESETN    (RESETN),
	.REG_ADDR  (REG_ADDR),
	.REG_WDATA (REG_WDATA),
	.REG_WR    (REG_WR),
	.REG_RD    (REG_RD),
	.REG_RDATA (REG_RDATA),
	.RX        (RX),
	.CLS       (CLS)
);

// ===== testbench/frame_source.sv
// received-frame source standing in for the port's receive side
`timescale 1ns/1ps
module frame_source (
	input  wire logic             clock,
	input  wire logic             start,
	input  wire logic [63:0][7:0] bytes_in,
	input  wire logic [6:0]       len,
	output classify_pkg::rx_t     rx,
	output logic                  busy
);
	import classify_pkg::*;
	logic [6:0] idx_ff;
	// one byte a cycle; idle data toggles so stale bytes never look valid by luck
	// one process owns every output, so nothing here has two drivers
	initial begin
		rx = '0;
		busy = 1'b0;
		idx_ff = 7'h0;
		forever begin
			@(posedge clock);
			if (busy || start) begin
				rx.valid <= 1'b1;
				rx.sof   <= (idx_ff == 7'h0);
				rx.eof   <= (idx_ff == len - 7'h1);
				rx.data  <= bytes_in[idx_ff[5:0]];
				busy     <= (idx_ff != len - 7'h1);
				idx_ff   <= (idx_ff == len - 7'h1) ? 7'h0 : idx_ff + 7'h1;
			end else begin
				rx.valid <= 1'b0;
				rx.sof   <= 1'b0;
				rx.eof   <= 1'b0;
				rx.data  <= ~rx.data;
			end
		end
	end
endmodule

// ===== testbench/tb_frame_classifier.sv
// register-driven bench for the received-frame classifier
`timescale 1ns/1ps
module tb_frame_classifier;
	import classify_pkg::*;
	logic             clock;
	logic             resetn;
	logic [9:0]       addr;
	logic [31:0]      wdata;
	logic             reg_wr;
	logic             reg_rd;
	logic [31:0]      rdata;
	rx_t              rx;
	cls_t             cls;
	logic             start;
	logic             busy;
	logic [63:0][7:0] frm;
	int               n_errors;
	int               cmp_count;
	frame_classifier frame_classifier_inst (
		.CLOCK(clock), .RESETN(resetn), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_RDATA(rdata), .RX(rx), .CLS(cls)
	);
	frame_source frame_source_inst (
		.clock(clock), .start(start), .bytes_in(frm), .len(7'h40), .rx(rx), .busy(busy)
	);
	// =============================================
	// helpers
	function automatic logic [9:0] fa(input logic [2:0] f, input logic [5:0] w);
		return {1'b0, f, w};
	endfunction
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		addr   <= a;
		wdata  <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [9:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_rd <= 1'b1;
		addr   <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		// the answer was registered at this edge and is gone at the next one
		#1;
		chk(rdata, exp);
	endtask
	task automatic frame(input logic [3:0] b, input logic [7:0] h);
		int n;
		@(posedge clock);
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		n = 0;
		while (cls.valid !== 1'b1 && n < 200) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n >= 200) begin
			n_errors++;
			report_and_stop();
		end else begin
			chk(32'(cls.branch), 32'(b));
			chk(32'(cls.hits), 32'(h));
			chk(32'(cls.onehot), 32'(9'h1 << b));
		end
	endtask
	// =============================================
	// clock and stimulus
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	initial begin
		n_errors = 0;
		cmp_count = 0;
		resetn = 1'b0;
		{addr, wdata, reg_wr, reg_rd, start} = '0;
		for (int i = 0; i < 64; i++) begin
			frm[i] = 8'(i);
		end
		frm[12] = 8'h08;
		frm[13] = 8'h00;
		frm[14] = 8'h45;
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		rd(10'h200, 32'h0);
		rd(10'h205, 32'h0);
		frame(4'h8, 8'h00);
		$display("test reset_default done");
		wr(fa(3'h5, 6'h0), 32'h1);
		wr(fa(3'h2, 6'h0), 32'h1);
		frame(4'h2, 8'h24);
		wr(fa(3'h0, 6'h9), 32'hff00_08ff);
		wr(fa(3'h0, 6'h0), 32'h9);
		frame(4'h0, 8'h25);
		wr(fa(3'h0, 6'h9), 32'hffff_08ff);
		frame(4'h2, 8'h24);
		wr(fa(3'h0, 6'h0), 32'h0);
		$display("test type_priority done");
		wr(fa(3'h1, 6'h2b), 32'hd);
		wr(fa(3'h1, 6'h2c), 32'h00fe_0044);
		wr(fa(3'h1, 6'h0), 32'h40_0001);
		frame(4'h1, 8'h26);
		wr(fa(3'h1, 6'h2c), 32'h00ff_0046);
		frame(4'h2, 8'h24);
		wr(fa(3'h1, 6'h0), 32'h0);
		$display("test generic done");
		// ip frame carrying a non-udp protocol must miss a wide-open port range
		wr(fa(3'h0, 6'h2a), 32'hffff_0000);
		wr(fa(3'h0, 6'h0), 32'h20_0001);
		frame(4'h2, 8'h24);
		$display("test udp_only done");
		wr(10'h200, 32'h0);
		frame(4'h2, 8'h24);
		rd(10'h200, 32'h1);
		rd(10'h212, 32'h1);
		rd(10'h218, 32'h0);
		rd(10'h201, 32'h2);
		$display("test counters done");
		// masked addresses: only the low byte of each address is compared
		wr(fa(3'h1, 6'h01), 32'h0000_0005);
		wr(fa(3'h1, 6'h03), 32'h0000_00ff);
		wr(fa(3'h1, 6'h05), 32'h0000_000b);
		wr(fa(3'h1, 6'h07), 32'h0000_00ff);
		wr(fa(3'h1, 6'h00), 32'h0000_0007);
		frame(4'h1, 8'h26);
		wr(fa(3'h1, 6'h05), 32'h0000_000c);
		frame(4'h2, 8'h24);
		$display("test mac done");
		// ipv4: masked source, protocol, dscp range with equal bounds
		wr(fa(3'h1, 6'h12), 32'h1a1b_1c1d);
		wr(fa(3'h1, 6'h13), 32'hffff_ff00);
		wr(fa(3'h1, 6'h16), 32'h0003_0317);
		wr(fa(3'h1, 6'h00), 32'h0000_d001);
		frame(4'h1, 8'h26);
		wr(fa(3'h1, 6'h16), 32'h0004_0417);
		frame(4'h2, 8'h24);
		$display("test ipv4 done");
		// udp payload: filter 0 still watches the whole destination range
		frm[23] <= 8'h11;
		frame(4'h0, 8'h25);
		wr(fa(3'h0, 6'h2a), 32'h2425_2425);
		frame(4'h0, 8'h25);
		wr(fa(3'h0, 6'h00), 32'h8020_0001);
		frame(4'h2, 8'h24);
		$display("test udp done");
		// two label entries, then a payload that is not ip
		frm[12] <= 8'h88;
		frm[13] <= 8'h47;
		wr(fa(3'h1, 6'h0d), 32'h0004_50f0);
		wr(fa(3'h1, 6'h0e), 32'h0004_50f1);
		wr(fa(3'h1, 6'h0f), 32'h0001_2131);
		wr(fa(3'h1, 6'h10), 32'h0001_2131);
		wr(fa(3'h1, 6'h11), 32'h0000_2200);
		wr(fa(3'h1, 6'h00), 32'h0000_0f01);
		frame(4'h1, 8'h26);
		wr(fa(3'h1, 6'h10), 32'h0001_2130);
		frame(4'h2, 8'h24);
		$display("test mpls done");
		// customer tag with vid 0x50f and priority 2, no service tag
		frm[12] <= 8'h81;
		frm[13] <= 8'h00;
		wr(fa(3'h1, 6'h0a), 32'h0fff_050f);
		wr(fa(3'h1, 6'h0c), 32'h0000_0072);
		wr(fa(3'h1, 6'h00), 32'h0000_0051);
		frame(4'h1, 8'h26);
		wr(fa(3'h1, 6'h00), 32'h0000_0071);
		frame(4'h2, 8'h24);
		$display("test vlan done");
		// ipv6: flow label 0xf1011, next header 0x14, dscp 0x14
		frm[12] <= 8'h86;
		frm[13] <= 8'hdd;
		wr(fa(3'h1, 6'h17), 32'h2223_2425);
		wr(fa(3'h1, 6'h1b), 32'hffff_ffff);
		wr(fa(3'h1, 6'h27), 32'h000f_1011);
		wr(fa(3'h1, 6'h28), 32'h000f_ffff);
		wr(fa(3'h1, 6'h29), 32'h0014_1414);
		wr(fa(3'h1, 6'h00), 32'h001d_0001);
		frame(4'h1, 8'h26);
		wr(fa(3'h1, 6'h29), 32'h0015_1514);
		frame(4'h2, 8'h24);
		$display("test ipv6 done");
		report_and_stop();
	end
endmodule
